// File: sp_cfg.svh
// Purpose: Constants for the single pin serial command port
// Assumes: Included by bare name
// Notes:   Offsets are set addresses and calibration indexes
`ifndef SP_CFG_SVH
`define SP_CFG_SVH

// ----------------------------------------
// Set addresses
// ----------------------------------------
`define SP_A_DH0    4'h0
`define SP_A_DH1    4'h1
`define SP_A_DH2    4'h2
`define SP_A_DH3    4'h3
`define SP_A_CALA   4'h6
`define SP_A_EEA1   4'h7
`define SP_A_PTR    4'h8
`define SP_A_CMD    4'h9
`define SP_A_ATIM   4'hA
`define SP_A_ALOC   4'hB
`define SP_A_RELRN  4'hF

// ----------------------------------------
// Command codes and bytes
// ----------------------------------------
`define SP_C_LDICR  4'h0
`define SP_C_RDICR  4'h3
`define SP_C_RDBK   4'h5
`define SP_B_RELRN  8'hFF
`define SP_LOCK_ON  8'hFF
`define SP_LOCK_OFF 8'h00

// ----------------------------------------
// Calibration indexes and reset values
// ----------------------------------------
`define SP_I_CFG    4'h0
`define SP_I_LOCK   4'h1
`define SP_RST16    16'h0000

// ----------------------------------------
// Field positions, gain map, timing
// ----------------------------------------
`define SP_F_TRIM   15:13
`define SP_F_CLIP   12:11
`define SP_F_SWAP   10
`define SP_F_OSGN   9
`define SP_F_OMAG   8:6
`define SP_F_GAIN   5:2
`define SP_F_OFFSET_DAC   1
`define SP_F_DRFT   0
`define SP_GAIN_BASE 8'h27
`define SP_GAIN_STEP 8'h0D
`define SP_BYTE_BITS 4'hA
`define SP_TX_BITS   4'hB
`define SP_LRN_BITS  4'h8

`endif

// File: sp_pkg.sv
// Purpose: Types for the single pin serial command port
// Assumes: Nothing
// Notes:   Configuration fields travel as one packed struct
package sp_pkg;

  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] clock_trim_code;
    logic [1:0] clip_sel;
    logic       bridge_swap;
    logic       coarse_offset_pos;
    logic [2:0] coarse_offset_mag;
    logic [3:0] gain_setting;
    logic       offset_dac_pos;
    logic       offset_drift_dac_pos;
  } sp_cfg_t;

  // ----------------------------------------
  // Port states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_LRN_IDLE, ST_LRN_LOW, ST_LRN_REST,
    ST_RX_IDLE, ST_RX_START, ST_RX_DATA, ST_RX_STOP,
    ST_TX_WAIT, ST_TX_BITS, ST_TX_GAP
  } sp_state_t;

endpackage : sp_pkg

// File: sp_cal_mem.sv
// Purpose: Calibration register store
// Assumes: Synchronous active low reset clears every entry
// Notes:   Read data come out of a register one cycle later
`timescale 1ns/1ns
`default_nettype none
`include "sp_cfg.svh"

module sp_cal_mem #(
  parameter int DW    = 16,
  parameter int AW    = 4,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_idx,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_ff [DEPTH];

  // ----------------------------------------
  // Entries
  // ----------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        mem_ff[i] <= `SP_RST16;
      end else if (wr_en && wr_idx == AW'(i)) begin
        mem_ff[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= `SP_RST16;
    end else begin
      rd_data <= mem_ff[rd_idx];
    end
  end

endmodule : sp_cal_mem
`default_nettype wire

// File: sp_port.sv
// Purpose: Single pin serial command port with baud learning
// Assumes: sys_clk is the internal oscillator; pin pulled up idle
// Notes:   Memory operations other than register access leave
//          through the command pulse outputs
`timescale 1ns/1ns
`default_nettype none
`include "sp_cfg.svh"

module sp_port
  import sp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Serial pin
  input  wire logic        serial_io_pin_in,
  output logic             serial_io_pin_out,
  output logic             serial_io_pin_oe_n,
  input  wire logic        unlock_pin,
  // Refresh from nonvolatile memory
  input  wire logic        analog_mode,
  input  wire logic        nvm_wr,
  input  wire logic [3:0]  nvm_idx,
  input  wire logic [15:0] nvm_data,
  // Configuration outputs
  output sp_cfg_t          cfg_out,
  output logic [7:0]       gain_value,
  output logic [3:0]       coarse_steps,
  output logic             out_to_amp,
  // Command outputs
  output logic             cmd_pulse,
  output logic [3:0]       command_to_logic,
  output logic [9:0]       eeprom_addr,
  output logic [15:0]      data_hold,
  output logic [3:0]       analog_time,
  output logic [3:0]       analog_loc,
  output logic [7:0]       bit_period_count
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sp_state_t   state_ff;
  sp_state_t   nxt_state;
  logic [2:0]  sync_ff;
  logic        line_ff;
  logic [8:0]  tmr_ff;
  logic [8:0]  nxt_tmr;
  logic [3:0]  bits_ff;
  logic [3:0]  nxt_bits;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_shift;
  logic [10:0] tx_ff;
  logic [10:0] nxt_tx;
  logic        byte_ok_ff;
  logic        nxt_byte_ok;
  logic [7:0]  lrn_ff;
  logic [7:0]  nxt_lrn;
  logic [15:0] cfg_ff;
  logic [15:0] lock_ff;
  logic [3:0]  cala_ff;
  logic [3:0]  eea1_ff;
  logic [3:0]  ptr_ff;
  logic        rd_pend_ff;
  logic [15:0] cal_rd;

  // ----------------------------------------
  // Pin synchroniser and line level
  // ----------------------------------------
  wire sync_agree = (sync_ff[1] == sync_ff[2]);
  wire fall       = line_ff && sync_agree && !sync_ff[2];
  wire rise       = !line_ff && sync_agree && sync_ff[2];
  wire line_lvl   = sync_agree ? sync_ff[2] : line_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_ff <= 3'h7;
      line_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], serial_io_pin_in};
      line_ff <= line_lvl;
    end
  end

  // ----------------------------------------
  // Decode of a received command byte
  // ----------------------------------------
  // address and data nibbles
  wire [3:0] rx_addr = shift_ff[3:0];
  wire [3:0] rx_data = shift_ff[7:4];
  wire [8:0] full_t  = {1'b0, bit_period_count};
  wire [8:0] half_t  = {2'b00, bit_period_count[7:1]};
  wire       tick    = (tmr_ff == 9'h000);

  // port open only unlocked or with pin high
  wire comm_en = unlock_pin ||
                 (lock_ff[7:0] == `SP_LOCK_OFF);

  wire relearn  = byte_ok_ff &&
                  (rx_addr == `SP_A_RELRN ||
                   shift_ff == `SP_B_RELRN);
  wire cmd_wr   = byte_ok_ff && rx_addr == `SP_A_CMD;
  wire run_ld   = cmd_wr && rx_data == `SP_C_LDICR;
  wire run_rd   = cmd_wr && rx_data == `SP_C_RDICR;
  wire run_rdbk = cmd_wr && rx_data == `SP_C_RDBK;

  wire [7:0] rdbk_byte =
    (ptr_ff == 4'h0) ? data_hold[7:0]  :
    (ptr_ff == 4'h1) ? data_hold[15:8] :
    (ptr_ff == 4'h2) ? bit_period_count :
    (ptr_ff == 4'h3) ? cfg_ff[7:0]     :
    (ptr_ff == 4'h4) ? cfg_ff[15:8]    :
    (ptr_ff == 4'h5) ? lock_ff[7:0]    : 8'h00;

  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_tmr     = tick ? 9'h000 : tmr_ff - 9'h001;
    nxt_bits    = bits_ff;
    nxt_shift   = shift_ff;
    nxt_tx      = tx_ff;
    nxt_byte_ok = 1'b0;
    nxt_lrn     = lrn_ff;
    case (state_ff)
      ST_LRN_IDLE: begin
        nxt_lrn = 8'h00;
        if (fall && comm_en) begin
          nxt_state = ST_LRN_LOW;
        end
      end
      // count start bit of learning byte
      ST_LRN_LOW: begin
        if (rise) begin
          nxt_state = ST_LRN_REST;
          nxt_tmr   = {2'b00, lrn_ff[7:1]};
          nxt_bits  = `SP_LRN_BITS;
        end else if (lrn_ff != 8'hFF) begin
          nxt_lrn = lrn_ff + 8'h01;
        end
      end
      // Let the rest of the learning byte pass
      ST_LRN_REST: begin
        if (tick) begin
          nxt_tmr  = full_t;
          nxt_bits = bits_ff - 4'h1;
          if (bits_ff == 4'h0) begin
            nxt_state = ST_RX_IDLE;
          end
        end
      end
      ST_RX_IDLE: begin
        if (fall && comm_en) begin
          nxt_state = ST_RX_START;
          nxt_tmr   = half_t;
        end
      end
      ST_RX_START: begin
        if (tick) begin
          nxt_tmr  = full_t;
          nxt_bits = 4'h0;
          nxt_state = line_ff ? ST_RX_IDLE : ST_RX_DATA;
        end
      end
      ST_RX_DATA: begin
        if (tick) begin
          nxt_tmr   = full_t;
          nxt_shift = {line_ff, shift_ff[7:1]};
          nxt_bits  = bits_ff + 4'h1;
          if (bits_ff == 4'h7) begin
            nxt_state = ST_RX_STOP;
          end
        end
      end
      // back to idle at mid stop bit
      ST_RX_STOP: begin
        if (tick) begin
          nxt_state   = ST_RX_IDLE;
          nxt_byte_ok = line_ff;
        end
      end
      ST_TX_WAIT: begin
        if (tick) begin
          nxt_tmr  = full_t;
          nxt_bits = bits_ff - 4'h1;
          if (bits_ff == 4'h1) begin
            nxt_state = ST_TX_BITS;
            nxt_bits  = `SP_TX_BITS;
          end
        end
      end
      ST_TX_BITS: begin
        if (tick) begin
          nxt_tmr  = full_t;
          nxt_tx   = {1'b1, tx_ff[10:1]};
          nxt_bits = bits_ff - 4'h1;
          if (bits_ff == 4'h1) begin
            nxt_state = ST_TX_GAP;
            nxt_bits  = `SP_BYTE_BITS;
          end
        end
      end
      // deaf for one byte after release
      ST_TX_GAP: begin
        if (tick) begin
          nxt_tmr  = full_t;
          nxt_bits = bits_ff - 4'h1;
          if (bits_ff == 4'h1) begin
            nxt_state = ST_RX_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_LRN_IDLE;
      end
    endcase
    if (relearn) begin
      nxt_state = ST_LRN_IDLE;
    end else if (run_rdbk) begin
      nxt_state = ST_TX_WAIT;
      nxt_tmr   = full_t;
      nxt_bits  = `SP_BYTE_BITS;
      nxt_tx    = {1'b1, rdbk_byte, 1'b0, 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff   <= ST_LRN_IDLE;
      tmr_ff     <= 9'h000;
      bits_ff    <= 4'h0;
      shift_ff   <= 8'h00;
      tx_ff      <= 11'h7FF;
      byte_ok_ff <= 1'b0;
      lrn_ff     <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      tmr_ff     <= nxt_tmr;
      bits_ff    <= nxt_bits;
      shift_ff   <= nxt_shift;
      tx_ff      <= nxt_tx;
      byte_ok_ff <= nxt_byte_ok;
      lrn_ff     <= nxt_lrn;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // drive only while sending
  wire nxt_drive = (nxt_state == ST_TX_BITS);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_io_pin_out  <= 1'b1;
      serial_io_pin_oe_n <= 1'b1;
    end else begin
      serial_io_pin_out  <= nxt_tx[0];
      serial_io_pin_oe_n <= !nxt_drive;
    end
  end

  // ----------------------------------------
  // Learned bit period
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_period_count <= 8'h00;
    end else if (state_ff == ST_LRN_LOW && rise) begin
      bit_period_count <= lrn_ff;
    end
  end

  // ----------------------------------------
  // Set registers
  // ----------------------------------------
  wire set_wr = byte_ok_ff && !relearn;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_hold   <= `SP_RST16;
      cala_ff     <= 4'h0;
      eea1_ff     <= 4'h0;
      ptr_ff      <= 4'h0;
      analog_time <= 4'h0;
      analog_loc  <= 4'h0;
    end else if (rd_pend_ff) begin
      data_hold <= cal_rd;
    end else if (set_wr) begin
      if (rx_addr == `SP_A_DH0) begin
        data_hold[3:0] <= rx_data;
      end else if (rx_addr == `SP_A_DH1) begin
        data_hold[7:4] <= rx_data;
      end else if (rx_addr == `SP_A_DH2) begin
        data_hold[11:8] <= rx_data;
      end else if (rx_addr == `SP_A_DH3) begin
        data_hold[15:12] <= rx_data;
      end else if (rx_addr == `SP_A_CALA) begin
        cala_ff <= rx_data;
      end else if (rx_addr == `SP_A_EEA1) begin
        eea1_ff <= rx_data;
      end else if (rx_addr == `SP_A_PTR) begin
        ptr_ff <= rx_data;
      end else if (rx_addr == `SP_A_ATIM) begin
        analog_time <= rx_data;
      end else if (rx_addr == `SP_A_ALOC) begin
        analog_loc <= rx_data;
      end
    end
  end

  // ----------------------------------------
  // Command execution
  // ----------------------------------------
  // every command write pulses out
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_pulse        <= 1'b0;
      command_to_logic <= 4'h0;
      eeprom_addr      <= 10'h000;
      rd_pend_ff       <= 1'b0;
    end else begin
      cmd_pulse  <= cmd_wr;
      rd_pend_ff <= run_rd;
      eeprom_addr <= {ptr_ff[1:0], eea1_ff, cala_ff};
      if (cmd_wr) begin
        command_to_logic <= rx_data;
      end
    end
  end

  wire       ref_wr = analog_mode && nvm_wr;
  wire       mem_wr = run_ld || ref_wr;
  wire [3:0] mem_ix = ref_wr ? nvm_idx : cala_ff;
  wire [15:0] mem_d = ref_wr ? nvm_data : data_hold;

  sp_cal_mem #(
    .DW    (16),
    .AW    (4),
    .DEPTH (16)
  ) u_cal (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (mem_wr),
    .wr_idx  (mem_ix),
    .wr_data (mem_d),
    .rd_idx  (cala_ff),
    .rd_data (cal_rd)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_ff  <= `SP_RST16;
      lock_ff <= `SP_RST16;
    end else if (mem_wr) begin
      if (mem_ix == `SP_I_CFG) begin
        cfg_ff <= mem_d;
      end
      if (mem_ix == `SP_I_LOCK) begin
        lock_ff <= mem_d;
      end
    end
  end

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  // gain from code
  wire [7:0] nxt_gain = `SP_GAIN_BASE +
                        8'(cfg_ff[`SP_F_GAIN]) * `SP_GAIN_STEP;
  // signed steps, zero for zero magnitude
  wire [3:0] mag4      = {1'b0, cfg_ff[`SP_F_OMAG]};
  wire [3:0] nxt_steps = cfg_ff[`SP_F_OSGN] ? mag4 : 4'h0 - mag4;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_out      <= '0;
      gain_value   <= `SP_GAIN_BASE;
      coarse_steps <= 4'h0;
      out_to_amp   <= 1'b0;
    end else begin
      cfg_out.clock_trim_code      <= cfg_ff[`SP_F_TRIM];
      cfg_out.clip_sel             <= cfg_ff[`SP_F_CLIP];
      cfg_out.bridge_swap          <= cfg_ff[`SP_F_SWAP];
      cfg_out.coarse_offset_pos    <= cfg_ff[`SP_F_OSGN];
      cfg_out.coarse_offset_mag    <= cfg_ff[`SP_F_OMAG];
      cfg_out.gain_setting         <= cfg_ff[`SP_F_GAIN];
      cfg_out.offset_dac_pos       <= cfg_ff[`SP_F_OFFSET_DAC];
      cfg_out.offset_drift_dac_pos <= cfg_ff[`SP_F_DRFT];
      gain_value   <= nxt_gain;
      coarse_steps <= nxt_steps;
      out_to_amp   <= (lock_ff[7:0] == `SP_LOCK_ON);
    end
  end

endmodule : sp_port
`default_nettype wire

// File: sp_port_sva.sv
// Purpose: Assertions on the serial command port outputs
// Assumes: Bound to sp_port; one clock domain
// Notes:   Sees only top module ports
`timescale 1ns/1ns
`default_nettype none

module sp_port_chk
  import sp_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Serial pin drive
  input wire logic        serial_io_pin_out,
  input wire logic        serial_io_pin_oe_n,
  // Refresh strobe
  input wire logic        nvm_wr,
  // Outputs watched
  input wire sp_cfg_t     cfg_out,
  input wire logic [7:0]  gain_value,
  input wire logic [3:0]  coarse_steps,
  input wire logic        out_to_amp,
  input wire logic        cmd_pulse,
  input wire logic [3:0]  command_to_logic,
  input wire logic [15:0] data_hold,
  input wire logic [7:0]  bit_period_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [11:0] drv_cnt_ff;
  logic [11:0] nxt_drv_cnt;
  logic [11:0] tx_len;
  logic [7:0]  gain_exp;
  logic [3:0]  mag_ext;
  logic [3:0]  steps_exp;

  // Cycles the device has driven the pin
  assign nxt_drv_cnt = serial_io_pin_oe_n ? 12'h000 : drv_cnt_ff + 12'h001;
  assign tx_len    = 12'h00B * ({4'h0, bit_period_count} + 12'h001);
  assign gain_exp  = 8'h27 + 8'h0D * {4'h0, cfg_out.gain_setting};
  assign mag_ext   = {1'b0, cfg_out.coarse_offset_mag};
  assign steps_exp = cfg_out.coarse_offset_pos ? mag_ext : 4'h0 - mag_ext;

  always_ff @(posedge sys_clk) begin
    drv_cnt_ff <= rst_n ? nxt_drv_cnt : 12'h000;
  end

  sequence s_tx_go;
    $fell(serial_io_pin_oe_n);
  endsequence
  sequence s_tx_done;
    $rose(serial_io_pin_oe_n);
  endsequence
  sequence s_load_cause;
    $past(cmd_pulse) || $past(cmd_pulse, 2) || $past(cmd_pulse, 3) ||
    $past(nvm_wr) || $past(nvm_wr, 2) || $past(nvm_wr, 3);
  endsequence

  a_reset_values: assert property (
    $rose(rst_n) |-> serial_io_pin_oe_n && serial_io_pin_out &&
      gain_value == 8'h27 && data_hold == 16'h0000 && cfg_out == 16'h0000)
    else $error("outputs not at reset values");
  a_gain_map: assert property ($stable(cfg_out) [*2]
    |-> gain_value == gain_exp) else $error("gain value wrong");
  a_offset_map: assert property ($stable(cfg_out) [*2]
    |-> coarse_steps == steps_exp) else $error("offset steps wrong");
  a_lead_high: assert property (s_tx_go |->
    (serial_io_pin_out && !serial_io_pin_oe_n)
      until $fell(serial_io_pin_out)) else $error("lead bit not high");
  a_start_bound: assert property (s_tx_go |->
    ##[1:256] $fell(serial_io_pin_out)) else $error("no start bit");
  a_stop_release: assert property (s_tx_done |->
    $past(serial_io_pin_out)) else $error("released before stop");
  a_frame_length: assert property (s_tx_done |->
    drv_cnt_ff == tx_len) else $error("drive length wrong");
  a_tx_code: assert property (s_tx_go |->
    command_to_logic == 4'h5) else $error("drive without readback");
  a_deaf_tx: assert property (!serial_io_pin_oe_n |->
    !cmd_pulse) else $error("command taken while driving");
  a_pulse_single: assert property (cmd_pulse |=>
    !cmd_pulse) else $error("command pulse too long");
  a_load_cause: assert property (
    $changed(cfg_out) || $changed(out_to_amp) |-> s_load_cause)
    else $error("word changed without load");
endmodule : sp_port_chk

bind sp_port sp_port_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n),
  .serial_io_pin_out(serial_io_pin_out),
  .serial_io_pin_oe_n(serial_io_pin_oe_n), .nvm_wr(nvm_wr),
  .cfg_out(cfg_out), .gain_value(gain_value),
  .coarse_steps(coarse_steps), .out_to_amp(out_to_amp),
  .cmd_pulse(cmd_pulse), .command_to_logic(command_to_logic),
  .data_hold(data_hold), .bit_period_count(bit_period_count)
);
`default_nettype wire

// File: sp_host.sv
// Purpose: Host calibration system on the serial line
// Assumes: Line pulled high when nobody drives
// Notes:   Bit time in clocks set through bit_t
`timescale 1ns/1ns
`default_nettype none

module sp_host (
  // Clock
  input  wire logic sys_clk,
  // Serial line
  input  wire logic line_lvl,
  output logic      host_val,
  output logic      host_oe
);
  int bit_t = 16;

  initial begin
    host_val = 1'b1;
    host_oe  = 1'b1;
  end

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_val <= frm[i];
      repeat (bit_t) @(posedge sys_clk);
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    host_oe <= 1'b0;
    while (line_lvl === 1'b1 && n < 40 * bit_t) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (bit_t / 2) @(posedge sys_clk);
    ok = (line_lvl === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_t) @(posedge sys_clk);
      b[i] = line_lvl;
    end
    repeat (bit_t) @(posedge sys_clk);
    ok = ok && (line_lvl === 1'b1);
    repeat (12 * bit_t) @(posedge sys_clk);
    host_oe <= 1'b1;
  endtask : recv_byte
endmodule : sp_host
`default_nettype wire

// File: sp_port_test.sv
// Purpose: Self-checking bench for the serial command port
// Assumes: Host model drives the line
// Notes:   Bit time 16 clocks, then 24 after relearn
`timescale 1ns/1ns
`default_nettype none

module sp_port_test
  import sp_pkg::*;
;
  logic        sys_clk, rst_n, unlock_pin, analog_mode, nvm_wr;
  logic [3:0]  nvm_idx, command_to_logic, coarse_steps, at, al;
  logic [15:0] nvm_data, data_hold;
  logic        pin_out, pin_oe_n, out_to_amp, cmd_pulse;
  logic        line_lvl, host_val, host_oe, ok;
  sp_cfg_t     cfg_out;
  logic [7:0]  gain_value, bit_period_count, b, ge;
  logic [3:0]  se;
  logic [9:0]  ea;
  logic [15:0] cfgs [3] = '{16'hB75A, 16'h08FD, 16'h0200};
  int          errors = 0;
  int          cmp_count = 0;

  // Wire level with pull-up
  assign line_lvl = !pin_oe_n ? pin_out : (host_oe ? host_val : 1'b1);

  sp_port dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .serial_io_pin_in(line_lvl), .serial_io_pin_out(pin_out),
    .serial_io_pin_oe_n(pin_oe_n), .unlock_pin(unlock_pin),
    .analog_mode(analog_mode), .nvm_wr(nvm_wr), .nvm_idx(nvm_idx),
    .nvm_data(nvm_data), .cfg_out(cfg_out), .gain_value(gain_value),
    .coarse_steps(coarse_steps), .out_to_amp(out_to_amp),
    .cmd_pulse(cmd_pulse), .command_to_logic(command_to_logic),
    .eeprom_addr(ea), .data_hold(data_hold), .analog_time(at),
    .analog_loc(al), .bit_period_count(bit_period_count));
  sp_host host (.sys_clk(sys_clk), .line_lvl(line_lvl),
    .host_val(host_val), .host_oe(host_oe));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input logic [7:0] lo, hi, g);
    cmp_count++;
    if (!(g >= lo && g <= hi) || $isunknown(g)) begin
      errors++;
      $display("unexpected %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    host.send_byte({d, a});
  endtask : wr

  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask : settle

  task automatic rd(input logic [3:0] p, output logic [7:0] v);
    wr(4'h8, p);
    wr(4'h9, 4'h5);
    host.recv_byte(v, ok);
    chk("frame", 16'h0001, {15'h0000, ok});
  endtask : rd

  task automatic ldcal(input logic [3:0] idx, input logic [15:0] v);
    for (int i = 0; i < 4; i++) wr(i[3:0], v[4*i +: 4]);
    wr(4'h6, idx);
    wr(4'h9, 4'h0);
    settle();
  endtask : ldcal

  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    unlock_pin = 1'b0;
    analog_mode = 1'b0;
    nvm_wr = 1'b0;
    nvm_idx = 4'h0;
    nvm_data = 16'h0000;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("gain", 16'h0027, {8'h00, gain_value});
    chk("cfg", 16'h0000, cfg_out);
    host.send_byte(8'h01);
    settle();
    chk_rng("bits", 8'h0E, 8'h10, bit_period_count);
    rd(4'h2, b);
    chk_rng("rb_bits", 8'h0E, 8'h10, b);
    wr(4'h0, 4'h4);
    wr(4'h1, 4'h3);
    wr(4'h2, 4'h2);
    wr(4'h3, 4'h1);
    wr(4'hA, 4'h6);
    wr(4'hB, 4'h9);
    wr(4'h7, 4'hC);
    wr(4'h4, 4'hF);
    wr(4'h5, 4'hF);
    wr(4'hC, 4'hF);
    wr(4'hD, 4'hF);
    wr(4'hE, 4'hF);
    settle();
    chk("hold", 16'h1234, data_hold);
    chk("atim", 16'h0006, {12'h000, at});
    chk("aloc", 16'h0009, {12'h000, al});
    chk("eeaddr", 16'h02C0, {6'h00, ea});
    foreach (cfgs[i]) begin
      ldcal(4'h0, cfgs[i]);
      ge = 8'h27 + 8'h0D * {4'h0, cfgs[i][5:2]};
      se = cfgs[i][9] ? {1'b0, cfgs[i][8:6]} : 4'h0 - {1'b0, cfgs[i][8:6]};
      chk("cfg", cfgs[i], cfg_out);
      chk("gain", {8'h00, ge}, {8'h00, gain_value});
      chk("steps", {12'h000, se}, {12'h000, coarse_steps});
    end
    rd(4'h3, b);
    chk("rb_lo", 16'h0000, {8'h00, b});
    rd(4'h4, b);
    chk("rb_hi", 16'h0002, {8'h00, b});
    for (int i = 0; i < 4; i++) wr(i[3:0], 4'h0);
    wr(4'h9, 4'h3);
    settle();
    chk("rdcal", 16'h0200, data_hold);
    for (int c = 1; c < 16; c++) begin
      if (c != 3 && c != 5) begin
        wr(4'h9, c[3:0]);
        settle();
        chk("code", 16'(c), {12'h000, command_to_logic});
      end
    end
    ldcal(4'h1, 16'h00FF);
    chk("amp", 16'h0001, {15'h0000, out_to_amp});
    wr(4'h0, 4'h7);
    settle();
    chk("locked", 16'h00FF, data_hold);
    unlock_pin <= 1'b1;
    ldcal(4'h1, 16'h0000);
    chk("amp", 16'h0000, {15'h0000, out_to_amp});
    unlock_pin <= 1'b0;
    host.send_byte(8'hFF);
    host.bit_t = 24;
    host.send_byte(8'h01);
    settle();
    chk_rng("bits", 8'h16, 8'h18, bit_period_count);
    wr(4'h0, 4'h9);
    settle();
    chk("hold", 16'h0009, data_hold);
    analog_mode <= 1'b1;
    nvm_data <= 16'hB75A;
    nvm_wr <= 1'b1;
    @(posedge sys_clk);
    nvm_wr <= 1'b0;
    settle();
    analog_mode <= 1'b0;
    chk("refresh", 16'hB75A, cfg_out);
    end_of_test();
  end
endmodule : sp_port_test
`default_nettype wire
